/* rtl/sdc_pkg.sv */
// constants and carrier types for the port capability/control register pair
// assumes byte addressing on a 32-bit avalon-mm register bus
package sdc_pkg;

   // ******************************************************
   // register map (byte addresses)
   // ******************************************************
   localparam logic [7:0] OFS_CAP = 8'hc4;
   localparam logic [7:0] OFS_CTRL = 8'hc8;
   localparam logic [7:0] OFS_EVT_STAT = 8'hd0;
   localparam logic [7:0] OFS_EVT_EN = 8'hd4;
   localparam logic [7:0] OFS_EVT_CLR = 8'hd8;

   // ******************************************************
   // field values and reset values
   // ******************************************************
   localparam logic [2:0] MPS_128 = 3'h0;
   localparam logic [2:0] MPS_256 = 3'h1;
   localparam logic [2:0] MPS_512 = 3'h2;
   localparam logic [2:0] LAT_RESET = 3'h0;
   localparam logic RBER_RESET = 1'b1;
   localparam logic [7:0] SPL_VALUE_RESET = 8'h00;
   localparam logic [1:0] SPL_SCALE_RESET = 2'h0;
   localparam logic [2:0] MRRS_FIXED = 3'h0;

   // ******************************************************
   // control word bit positions
   // ******************************************************
   localparam int CTRL_MPS_LSB = 5;
   localparam int CTRL_AUX_BIT = 10;

   // ******************************************************
   // event bits and timing
   // ******************************************************
   localparam int EVT_W = 5;
   localparam int EVT_SPL_BIT = 4;
   localparam logic [1:0] STRAP_TAKE_CNT = 2'h2;

   typedef struct packed {
      logic [2:0] mps_sup;
      logic rber;
   } sdc_sideband_t;

   typedef struct packed {
      logic [7:0] value;
      logic [1:0] scale;
   } sdc_slot_pwr_t;

endpackage : sdc_pkg

/* rtl/sdc_sync.sv */
// two-flop synchroniser for pin inputs
// assumes the pin is asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none

module sdc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // pin and synchronised level
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta;

   // ******************************************************
   // capture stages
   // ******************************************************
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= pin_i;
         sync_o <= meta;
      end
   end

endmodule : sdc_sync

`default_nettype wire

/* rtl/sdc_irq.sv */
// sticky event status, enable mask and one level interrupt
// assumes event and clear strobes on clock_i
`timescale 1ns/1ps
`default_nettype none

module sdc_irq #(
   parameter int N = 5
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // events and software access
   input wire logic [N-1:0] event_i,
   input wire logic [N-1:0] clear_i,
   input wire logic en_we_i,
   input wire logic [N-1:0] en_data_i,
   // state
   output logic [N-1:0] status_o,
   output logic [N-1:0] enable_o,
   output logic irq_o
);

   logic [N-1:0] next_status;

   // set wins over a clear in the same cycle
   always_comb begin
      next_status = (status_o & ~clear_i) | event_i;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else begin
         status_o <= next_status;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         enable_o <= '0;
      end else if (en_we_i) begin
         enable_o <= en_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(next_status & (en_we_i ? en_data_i : enable_o));
      end
   end

endmodule : sdc_irq

`default_nettype wire

/* rtl/sdc_regs.sv */
// port capability and control registers behind an avalon-mm slave
// assumes one master, side-band and message strobes on clock_i, strap pin asynchronous
`timescale 1ns/1ps
`default_nettype none

// Function
// (RULE1) payload capability codes 128/256/512, others reserved
// (RULE2) strap selects 256 or 512 at reset
// (RULE3) side-band loader overrides payload capability
// (RULE4) phantom functions field reads zero
// (RULE5) extended tag supported reads zero
// (RULE6) acceptable latency fields read zero
// (RULE7) role-based error bit resets one, loader-overridable
// (RULE8) upstream captures slot power value, else zero
// (RULE9) upstream captures slot power scale, else zero
// (RULE10) four error reporting enables, reset zero
// (RULE11) relaxed ordering, no snoop read zero
// (RULE12) payload setting read-write, reset zero
// (RULE13) oversize payload setting clamps to capability
// (RULE14) extended tag, phantom enables read zero
// (RULE15) auxiliary power enable read-write, reset zero
// (RULE16) read request size hardwired zero
// (RULE17) error flags set regardless of enables
// (RULE18) reserved bits read zero, writes ignored
module sdc_regs #(
   parameter int ADDR_W = 8,
   parameter logic IS_UPSTREAM = 1'b1
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // strap and side-band loader
   input wire logic large_body_strap_i,
   input wire logic sb_load_i,
   input wire sdc_pkg::sdc_sideband_t sb_data_i,
   // slot power message
   input wire logic spl_valid_i,
   input wire sdc_pkg::sdc_slot_pwr_t spl_data_i,
   // error events
   input wire logic [3:0] err_event_i,
   // control outputs
   output logic [3:0] err_report_o,
   output logic [2:0] mps_o,
   output logic aux_pwr_en_o,
   output logic irq_o
);

   // ******************************************************
   // declarations
   // ******************************************************
   logic [2:0] mps_sup;
   logic rber;
   sdc_pkg::sdc_slot_pwr_t spl;
   logic [3:0] err_en;
   logic strap_sync;
   logic [1:0] strap_cnt;
   logic strap_take;
   logic req;
   logic wr_fire;
   logic [31:0] cap_word;
   logic [31:0] ctrl_word;
   logic [31:0] next_rdata;
   logic [sdc_pkg::EVT_W-1:0] evt_status;
   logic [sdc_pkg::EVT_W-1:0] evt_enable;
   logic [sdc_pkg::EVT_W-1:0] evt_clear;
   logic [sdc_pkg::EVT_W-1:0] evt_in;
   logic evt_en_we;
   logic [2:0] wr_mps;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction : hit

   function automatic logic sup_code_ok(input logic [2:0] c);
      sup_code_ok = (c <= sdc_pkg::MPS_512);
   endfunction : sup_code_ok

   // ******************************************************
   // strap capture
   // ******************************************************
   sdc_sync #(
      .W(1)
   ) u_strap_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pin_i(large_body_strap_i),
      .sync_o(strap_sync)
   );

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         strap_cnt <= 2'h0;
      end else if (strap_cnt != 2'h3) begin
         strap_cnt <= strap_cnt + 2'h1;
      end
   end

   assign strap_take = (strap_cnt == sdc_pkg::STRAP_TAKE_CNT);

   // ******************************************************
   // capability word state
   // ******************************************************
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         mps_sup <= sdc_pkg::MPS_256;
      end else if (sb_load_i && sup_code_ok(sb_data_i.mps_sup)) begin
         mps_sup <= sb_data_i.mps_sup; // RULE3
      end else if (strap_take) begin
         mps_sup <= strap_sync ? sdc_pkg::MPS_512 : sdc_pkg::MPS_256; // RULE2
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rber <= sdc_pkg::RBER_RESET; // RULE7
      end else if (sb_load_i) begin
         rber <= sb_data_i.rber; // RULE7
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         spl.value <= sdc_pkg::SPL_VALUE_RESET;
         spl.scale <= sdc_pkg::SPL_SCALE_RESET;
      end else if (IS_UPSTREAM && spl_valid_i) begin
         spl.value <= spl_data_i.value; // RULE8
         spl.scale <= spl_data_i.scale; // RULE9
      end
   end

   // RULE1 RULE4 RULE5 RULE6 RULE18
   assign cap_word = {4'h0, spl.scale, spl.value, 2'h0, rber, 3'h0,
                      sdc_pkg::LAT_RESET, sdc_pkg::LAT_RESET, 1'b0, 2'h0, mps_sup};

   // RULE11 RULE14 RULE16 RULE18
   assign ctrl_word = {16'h0, 1'b0, sdc_pkg::MRRS_FIXED, 1'b0, aux_pwr_en_o,
                       2'h0, mps_o, 1'b0, err_en};

   // ******************************************************
   // avalon handshake
   // ******************************************************
   assign req = avs_read_i || avs_write_i;
   assign wr_fire = avs_write_i && !avs_waitrequest_o;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if (req) begin
         avs_waitrequest_o <= 1'b0;
      end
   end

   always_comb begin
      next_rdata = 32'h0;
      if (hit(avs_address_i, sdc_pkg::OFS_CAP)) begin
         next_rdata = cap_word;
      end else if (hit(avs_address_i, sdc_pkg::OFS_CTRL)) begin
         next_rdata = ctrl_word;
      end else if (hit(avs_address_i, sdc_pkg::OFS_EVT_STAT)) begin
         next_rdata = {{(32 - sdc_pkg::EVT_W){1'b0}}, evt_status};
      end else if (hit(avs_address_i, sdc_pkg::OFS_EVT_EN)) begin
         next_rdata = {{(32 - sdc_pkg::EVT_W){1'b0}}, evt_enable};
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= next_rdata;
      end
   end

   // ******************************************************
   // control word writes
   // ******************************************************
   assign wr_mps = avs_writedata_i[sdc_pkg::CTRL_MPS_LSB +: 3];

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         err_en <= 4'h0; // RULE10
         mps_o <= sdc_pkg::MPS_128; // RULE12
      end else if (wr_fire && hit(avs_address_i, sdc_pkg::OFS_CTRL) && avs_byteenable_i[0]) begin
         err_en <= avs_writedata_i[3:0]; // RULE10
         mps_o <= (wr_mps > mps_sup) ? mps_sup : wr_mps; // RULE12 RULE13
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         aux_pwr_en_o <= 1'b0; // RULE15
      end else if (wr_fire && hit(avs_address_i, sdc_pkg::OFS_CTRL) && avs_byteenable_i[1]) begin
         aux_pwr_en_o <= avs_writedata_i[sdc_pkg::CTRL_AUX_BIT]; // RULE15
      end
   end

   // ******************************************************
   // error reporting and events
   // ******************************************************
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         err_report_o <= 4'h0;
      end else begin
         err_report_o <= err_event_i & err_en; // RULE10
      end
   end

   // RULE17
   assign evt_in = {IS_UPSTREAM && spl_valid_i, err_event_i};
   assign evt_clear = (wr_fire && hit(avs_address_i, sdc_pkg::OFS_EVT_CLR) && avs_byteenable_i[0])
                      ? avs_writedata_i[sdc_pkg::EVT_W-1:0] : '0;
   assign evt_en_we = wr_fire && hit(avs_address_i, sdc_pkg::OFS_EVT_EN) && avs_byteenable_i[0];

   sdc_irq #(
      .N(sdc_pkg::EVT_W)
   ) u_irq (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .event_i(evt_in),
      .clear_i(evt_clear),
      .en_we_i(evt_en_we),
      .en_data_i(avs_writedata_i[sdc_pkg::EVT_W-1:0]),
      .status_o(evt_status),
      .enable_o(evt_enable),
      .irq_o(irq_o)
   );

   // ******************************************************
   // checks
   // ******************************************************
   default clocking cb @(posedge clock_i);
   endclocking

   default disable iff (rst_i);

   logic rd_cap_done;
   logic rd_ctrl_done;
   logic ctrl_lo_wr;
   assign rd_cap_done = avs_read_i && !avs_waitrequest_o && hit(avs_address_i, sdc_pkg::OFS_CAP);
   assign rd_ctrl_done = avs_read_i && !avs_waitrequest_o && hit(avs_address_i, sdc_pkg::OFS_CTRL);
   assign ctrl_lo_wr = wr_fire && hit(avs_address_i, sdc_pkg::OFS_CTRL) && avs_byteenable_i[0];

   bus_answer_a: assert property (req && avs_waitrequest_o |-> ##1 !avs_waitrequest_o)
      else $error("request not answered in one cycle");

   sup_code_a: assert property (mps_sup <= 3'h2) // RULE1
      else $error("payload capability holds a reserved code");

   strap_load_a: assert property (strap_take && !sb_load_i |=> // RULE2
      mps_sup == ($past(strap_sync) ? 3'h2 : 3'h1))
      else $error("strap value not loaded");

   sb_load_a: assert property (sb_load_i && sb_data_i.mps_sup <= 3'h2 |=> // RULE3
      mps_sup == $past(sb_data_i.mps_sup) && rber == $past(sb_data_i.rber))
      else $error("side-band load not taken");

   cap_fixed_a: assert property (rd_cap_done |-> avs_readdata_o[4:3] == 2'h0) // RULE4
      else $error("phantom field not zero");

   ext_tag_a: assert property (rd_cap_done |-> !avs_readdata_o[5]) // RULE5
      else $error("extended tag capability not zero");

   latency_a: assert property (rd_cap_done |-> avs_readdata_o[11:6] == 6'h0) // RULE6
      else $error("latency fields not zero");

   rber_reset_a: assert property ($fell(rst_i) |-> rber) // RULE7
      else $error("role-based bit not set after reset");

   spl_capture_a: assert property (spl_valid_i |=> // RULE8
      spl.value == (IS_UPSTREAM ? $past(spl_data_i.value) : 8'h00))
      else $error("slot power value wrong");

   spl_scale_a: assert property (spl_valid_i |=> // RULE9
      spl.scale == (IS_UPSTREAM ? $past(spl_data_i.scale) : 2'h0))
      else $error("slot power scale wrong");

   err_report_a: assert property (err_event_i[0] && err_en[0] |=> err_report_o[0]) // RULE10
      else $error("enabled error not reported");

   ctrl_ro_a: assert property (rd_ctrl_done |-> // RULE11
      !avs_readdata_o[4] && !avs_readdata_o[11])
      else $error("ordering or snoop enable not zero");

   mps_reset_a: assert property ($fell(rst_i) |-> // RULE10 RULE12 RULE15
      mps_o == 3'h0 && !aux_pwr_en_o && err_en == 4'h0)
      else $error("payload setting not reset");

   mps_clamp_a: assert property (ctrl_lo_wr && wr_mps > mps_sup |=> // RULE13
      mps_o == $past(mps_sup))
      else $error("payload setting not clamped");

   tag_phantom_a: assert property (rd_ctrl_done |-> avs_readdata_o[9:8] == 2'h0) // RULE14
      else $error("tag or phantom enable not zero");

   aux_write_a: assert property (wr_fire && hit(avs_address_i, sdc_pkg::OFS_CTRL) // RULE15
      && avs_byteenable_i[1] |=> aux_pwr_en_o == $past(avs_writedata_i[10]))
      else $error("aux power enable not written");

   mrrs_zero_a: assert property (rd_ctrl_done |-> avs_readdata_o[14:12] == 3'h0) // RULE16
      else $error("read request size not zero");

   err_flag_a: assert property (err_event_i[3] |=> evt_status[3]) // RULE17
      else $error("error flag not set");

   reserved_a: assert property (rd_ctrl_done |-> avs_readdata_o[31:15] == 17'h0) // RULE18
      else $error("reserved control bits not zero");

   irq_level_a: assert property (|(evt_status & evt_enable) |-> irq_o)
      else $error("interrupt low with enabled status");

   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   err_mask_a: assert property (!err_en[1] |=> !err_report_o[1]) // RULE10
      else $error("disabled error reported");

   err_flag_lo_a: assert property (err_event_i[1] && !err_en[1] |=> evt_status[1]) // RULE17
      else $error("error flag not set while reporting disabled");

   aux_keep_a: assert property (!(wr_fire && avs_byteenable_i[1]) |=> $stable(aux_pwr_en_o)) // RULE15
      else $error("aux power enable changed without a write");

   spl_hold_a: assert property (!spl_valid_i |=> $stable(spl)) // RULE8 RULE9
      else $error("slot power field changed without a message");

   read_cap_c: cover property (rd_cap_done);
   clamp_c: cover property (ctrl_lo_wr && wr_mps > mps_sup);
   irq_rise_c: cover property ($rose(irq_o));
   spl_c: cover property (spl_valid_i ##[1:8] rd_cap_done);
   strap_c: cover property (strap_take && strap_sync);

endmodule : sdc_regs

`default_nettype wire

/* testbench/switch_port_device_cap_ctrl_regs_bench.sv */
// self-checking bench for the port capability/control register pair
// assumes sdc_pkg and sdc_regs are compiled first; the bench drives every dut input itself
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) begin checks_done++; if ((g) !== 32'(e)) begin failures++; \
   $display("mismatch at %0t: got %h expected %h", $time, (g), 32'(e)); end end

module switch_port_device_cap_ctrl_regs_bench;
   // ******************************************************
   // signals and model state
   // ******************************************************
   logic clk = 1'b0;
   logic rst, rd, wr, wait_req, strap, sb_load, spl_valid, aux, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, rdat_dn, q_dn;
   logic [3:0] be, err_ev, err_rep;
   logic [2:0] mps;
   sdc_pkg::sdc_sideband_t sb_data;
   sdc_pkg::sdc_slot_pwr_t spl_data;
   int failures, checks_done, cycles;
   int m_sup, m_rber, m_val, m_scl, m_en, m_mps, m_aux, m_stat;

   always #12.5 clk = ~clk;

   sdc_regs #(.ADDR_W(8), .IS_UPSTREAM(1'b1)) i_dut (
      .clock_i(clk), .rst_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
      .large_body_strap_i(strap), .sb_load_i(sb_load), .sb_data_i(sb_data),
      .spl_valid_i(spl_valid), .spl_data_i(spl_data), .err_event_i(err_ev),
      .err_report_o(err_rep), .mps_o(mps), .aux_pwr_en_o(aux), .irq_o(irq)
   );

   // downstream copy on the same bus: slot power message must not land
   sdc_regs #(.ADDR_W(8), .IS_UPSTREAM(1'b0)) i_dut_dn (
      .clock_i(clk), .rst_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(be), .avs_readdata_o(rdat_dn), .avs_waitrequest_o(),
      .large_body_strap_i(strap), .sb_load_i(sb_load), .sb_data_i(sb_data),
      .spl_valid_i(spl_valid), .spl_data_i(spl_data), .err_event_i(err_ev),
      .err_report_o(), .mps_o(), .aux_pwr_en_o(), .irq_o()
   );

   // ******************************************************
   // model and bus tasks
   // ******************************************************
   function automatic int cap_exp();
      return (m_scl << 26) | (m_val << 18) | (m_rber << 15) | m_sup;
   endfunction : cap_exp

   function automatic int ctrl_exp();
      return (m_aux << 10) | (m_mps << 5) | m_en;
   endfunction : ctrl_exp

   task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      be <= b;
      wr <= w;
      rd <= ~w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 64);
      q = rdat;
      q_dn = rdat_dn;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 64) failures++;
   endtask : bus_xfer

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] q;
      bus_xfer(1'b1, a, d, b, q);
   endtask : wr_reg

   task automatic rd_cmp(input logic [7:0] a, input int e);
      logic [31:0] q;
      bus_xfer(1'b0, a, 32'h0, 4'hf, q);
      `chk(q, e)
   endtask : rd_cmp

   task automatic ctrl_wr(input logic [31:0] d, input logic [3:0] b);
      int mv;
      wr_reg(sdc_pkg::OFS_CTRL, d, b);
      mv = int'(d[7:5]);
      if (b[0]) m_en = int'(d[3:0]);
      if (b[0]) m_mps = (mv > m_sup) ? m_sup : mv;
      if (b[1]) m_aux = int'(d[10]);
   endtask : ctrl_wr

   task automatic do_reset(input logic s);
      @(posedge clk);
      strap <= s;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      m_sup = s ? 2 : 1;
      m_rber = 1;
      {m_val, m_scl, m_en, m_mps, m_aux, m_stat} = '0;
   endtask : do_reset

   task automatic sb_pulse(input logic [2:0] m, input logic r);
      @(posedge clk);
      sb_load <= 1'b1;
      sb_data <= {m, r};
      @(posedge clk);
      sb_load <= 1'b0;
      sb_data <= 4'($urandom);
      if (m <= 3'h2) m_sup = int'(m);
      m_rber = int'(r);
   endtask : sb_pulse

   task automatic pulse_in(input logic [3:0] e, input logic s);
      logic [9:0] v;
      v = 10'($urandom);
      @(posedge clk);
      err_ev <= e;
      spl_valid <= s;
      spl_data <= v;
      @(posedge clk);
      err_ev <= 4'h0;
      spl_valid <= 1'b0;
      #1;
      m_stat = m_stat | int'(e) | (s ? 16 : 0);
      if (s) m_val = int'(v[9:2]);
      if (s) m_scl = int'(v[1:0]);
   endtask : pulse_in

   task automatic irq_cmp(input int e);
      @(posedge clk);
      #1;
      `chk(irq, e)
   endtask : irq_cmp

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   // ******************************************************
   // tests
   // ******************************************************
   initial begin
      void'($urandom(47));
      {rst, rd, wr, strap, sb_load, spl_valid} <= 6'h20;
      {adr, wdat, be, err_ev} <= '0;
      sb_data <= '0;
      spl_data <= '0;
      do_reset(1'b0);
      rd_cmp(sdc_pkg::OFS_CAP, 32'h0000_8001);
      rd_cmp(sdc_pkg::OFS_CTRL, 0);
      `chk(mps, 0)
      $display("test reset values done");

      for (int i = 0; i < 8; i++) begin
         sb_pulse(3'(i), 1'($urandom));
         rd_cmp(sdc_pkg::OFS_CAP, cap_exp());
      end
      $display("test side-band load done");

      ctrl_wr(32'hffff_ffff, 4'hf);
      rd_cmp(sdc_pkg::OFS_CTRL, ctrl_exp());
      for (int i = 0; i < 12; i++) begin
         ctrl_wr($urandom, 4'($urandom));
         rd_cmp(sdc_pkg::OFS_CTRL, ctrl_exp());
         `chk(mps, m_mps)
         `chk(aux, m_aux)
      end
      $display("test control word done");

      for (int i = 0; i < 4; i++) begin
         pulse_in(4'h0, 1'b1);
         rd_cmp(sdc_pkg::OFS_CAP, cap_exp());
         `chk(q_dn, cap_exp() & 32'h0003_ffff)
      end
      $display("test slot power done");

      ctrl_wr(32'h0000_0005, 4'h1);
      for (int i = 0; i < 5; i++) begin
         pulse_in(4'(1 << i), 1'b0);
         `chk(err_rep, (1 << i) & m_en)
      end
      rd_cmp(sdc_pkg::OFS_EVT_STAT, m_stat);
      wr_reg(sdc_pkg::OFS_EVT_EN, 32'h1f, 4'h1);
      irq_cmp(1);
      rd_cmp(sdc_pkg::OFS_EVT_EN, 32'h1f);
      wr_reg(sdc_pkg::OFS_EVT_CLR, 32'h0f, 4'h1);
      m_stat = m_stat & 16;
      rd_cmp(sdc_pkg::OFS_EVT_STAT, m_stat);
      rd_cmp(sdc_pkg::OFS_EVT_CLR, 0);
      wr_reg(sdc_pkg::OFS_EVT_EN, 32'h0f, 4'h1);
      irq_cmp(0);
      wr_reg(sdc_pkg::OFS_EVT_EN, 32'h10, 4'h1);
      irq_cmp(1);
      wr_reg(sdc_pkg::OFS_EVT_CLR, 32'h1f, 4'h1);
      irq_cmp(0);
      $display("test errors and interrupt done");

      wr_reg(sdc_pkg::OFS_CAP, 32'hffff_ffff, 4'hf);
      rd_cmp(sdc_pkg::OFS_CAP, cap_exp());
      wr_reg(8'he0, 32'hffff_ffff, 4'hf);
      rd_cmp(8'he0, 0);
      $display("test read-only and unmapped done");

      do_reset(1'b1);
      rd_cmp(sdc_pkg::OFS_CAP, 32'h0000_8002);
      ctrl_wr(32'h0000_00e0, 4'h1);
      rd_cmp(sdc_pkg::OFS_CTRL, ctrl_exp());
      $display("test strap high done");
      tally_and_finish();
   end
endmodule : switch_port_device_cap_ctrl_regs_bench
`default_nettype wire
